// File: shared/cpc_pkg.sv
// Purpose: Constants and types of the CPRI parallel codec path
// Assumes: Code-group bit 9 holds bit a, the first bit on the line
// Notes:   Coding tables hold the negative-disparity forms only
package cpc_pkg;
   localparam int unsigned CW = 10;
   localparam int unsigned AW = 4;
   localparam int unsigned DW = 32;

   // ****************************************
   // Line code tables
   // ****************************************
   // 5b/6b codes abcdei, entry x at [6x+5:6x]
   localparam logic [191:0] T6_NEG =
      192'hadeb8e_d969b3_e9aa8b_c938db_5dcb0d_d15979_e19a75_c6d767;
   // 3b/4b codes fghj, entry y at [4y+3:4y]
   localparam logic [31:0]  T4_NEG    = 32'he6adc59b;
   localparam logic [4:0]   K28_X     = 5'h1c;
   localparam logic [5:0]   K28_SIX   = 6'h0f;
   localparam logic [5:0]   D7_SIX    = 6'h38;
   localparam logic [3:0]   X3_FOUR   = 4'hc;
   localparam logic [3:0]   ALT_FOUR  = 4'h7;
   localparam logic [2:0]   Y7        = 3'h7;
   // One bit per x value
   localparam logic [31:0]  ALT_NEG_X = 32'h00160000;
   localparam logic [31:0]  ALT_POS_X = 32'h00006800;
   localparam logic [31:0]  K_Y7_X    = 32'h68800000;
   localparam logic [6:0]   COMMA_POS = 7'h1f;
   localparam logic [6:0]   COMMA_NEG = 7'h60;
   localparam int unsigned  ONES6     = 3;
   localparam int unsigned  ONES4     = 2;
   localparam int unsigned  ONES10    = 5;

   // ****************************************
   // Registers and timing
   // ****************************************
   localparam logic [AW-1:0] ADR_CTRL   = 4'h0;
   localparam logic [AW-1:0] ADR_STATUS = 4'h4;
   localparam logic [AW-1:0] ADR_IRQ    = 4'h8;
   localparam logic [AW-1:0] ADR_MASK   = 4'hc;
   localparam logic [3:0]    CTRL_RST   = 4'h0;
   localparam logic [3:0]    MASK_RST   = 4'h0;
   // Low phase of the recovered word clock
   localparam logic [1:0]    REC_LOW_CYC = 2'h2;

   // rate_low: 0 = 1228.8 Mbps, 1 = 614.4 Mbps
   typedef struct packed {
      logic rate_low;
      logic read_mode;
      logic align_en;
      logic mode8;
   } cpc_ctrl_t;

   typedef struct packed {
      logic lock_lost;
      logic sig_lost;
      logic comma;
      logic viol;
   } cpc_evt_t;

   typedef struct packed {
      logic       viol;
      logic       k;
      logic [7:0] data;
   } cpc_rxw_t;
endpackage : cpc_pkg

// File: rtl/cpc_codec_path.sv
// Purpose: Parallel word path of a CPRI serdes with 8b/10b coding
// Assumes: Bit strobes from the deserializer share clk_i
// Notes:   Word clocks from pins are sampled, not used as clocks
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module cpc_codec_path (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic [cpc_pkg::AW-1:0] wb_adr_i,
   input  wire logic [cpc_pkg::DW-1:0] wb_dat_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic                 wb_we_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   output logic [cpc_pkg::DW-1:0]    wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      irq_o,
   input  wire logic                 tx_word_clock_i,
   input  wire logic [cpc_pkg::CW-1:0] tx_word_i,
   output logic [cpc_pkg::CW-1:0]    tx_code_o,
   output logic                      tx_code_stb_o,
   output logic                      rate_sel_o,
   input  wire logic                 rx_bit_i,
   input  wire logic                 rx_bit_stb_i,
   input  wire logic                 rx_pll_locked_i,
   input  wire logic                 rx_sig_detect_i,
   output logic [cpc_pkg::CW-1:0]    rx_parallel_word_o,
   input  wire logic                 rx_word_clock_i,
   output logic                      rx_word_clock_o,
   output logic                      rx_word_clock_oe_o,
   output logic                      signal_loss_flag_o,
   output logic                      rx_pll_lock_n_o,
   output logic                      comma_detect_flag_o
);

   // ****************************************
   // 8b/10b coder
   // ****************************************
   // Returns {rd_next, code}
   function automatic logic [10:0] enc(
      input logic [7:0] d,
      input logic       k,
      input logic       rd
   );
      logic [5:0] s;
      logic [3:0] f;
      logic       r1;
      logic       k28;
      logic       alt;
      k28 = k && (d[4:0] == cpc_pkg::K28_X);
      s   = k28 ? cpc_pkg::K28_SIX : cpc_pkg::T6_NEG[d[4:0]*6 +: 6];
      // K28 is built negative, then inverted whole when rd is set
      r1  = k28 ? 1'b0 : rd;
      if (r1 && ($countones(s) != cpc_pkg::ONES6 || s == cpc_pkg::D7_SIX))
         s = ~s;
      r1  = r1 ^ ($countones(s) != cpc_pkg::ONES6);
      // Alternate x.7 avoids a run of five equal bits
      alt = (d[7:5] == cpc_pkg::Y7) && (k ||
            (!r1 && cpc_pkg::ALT_NEG_X[d[4:0]]) ||
            (r1 && cpc_pkg::ALT_POS_X[d[4:0]]));
      f   = alt ? cpc_pkg::ALT_FOUR : cpc_pkg::T4_NEG[d[7:5]*4 +: 4];
      if (r1 && ($countones(f) != cpc_pkg::ONES4 || f == cpc_pkg::X3_FOUR))
         f = ~f;
      enc[9:0] = (k28 && rd) ? ~{s, f} : {s, f};
      enc[10]  = rd ^ ($countones(enc[9:0]) != cpc_pkg::ONES10);
   endfunction : enc

   // Returns {rd_next, viol, k, data}
   function automatic logic [10:0] dec(
      input logic [9:0] c,
      input logic       rd
   );
      logic [7:0]  d;
      logic        k;
      logic [3:0]  f;
      logic [5:0]  t6;
      logic [3:0]  t4;
      logic [10:0] e;
      d = 8'h00;
      k = 1'b0;
      f = c[3:0];
      for (int i = 0; i < 32; i++) begin
         t6 = cpc_pkg::T6_NEG[i*6 +: 6];
         if (c[9:4] == t6 || ((c[9:4] == ~t6) &&
             ($countones(t6) != cpc_pkg::ONES6 || t6 == cpc_pkg::D7_SIX)))
            d[4:0] = 5'(i);
      end
      if (c[9:4] == cpc_pkg::K28_SIX || c[9:4] == ~cpc_pkg::K28_SIX) begin
         d[4:0] = cpc_pkg::K28_X;
         k      = 1'b1;
         if (c[9:4] == ~cpc_pkg::K28_SIX)
            f = ~c[3:0];
      end
      for (int j = 0; j < 8; j++) begin
         t4 = cpc_pkg::T4_NEG[j*4 +: 4];
         if (f == t4 || ((f == ~t4) &&
             ($countones(t4) != cpc_pkg::ONES4 || t4 == cpc_pkg::X3_FOUR)))
            d[7:5] = 3'(j);
      end
      if (f == cpc_pkg::ALT_FOUR || f == ~cpc_pkg::ALT_FOUR) begin
         d[7:5] = cpc_pkg::Y7;
         k      = k | cpc_pkg::K_Y7_X[d[4:0]];
      end
      // Re-encoding catches bad codes and disparity errors alike
      e   = enc(d, k, rd);
      dec = {rd ^ ($countones(c) != cpc_pkg::ONES10), e[9:0] != c, k, d};
   endfunction : dec

   // ****************************************
   // Pin synchronisers
   // ****************************************
   cpc_pkg::cpc_ctrl_t   ctrl_reg;
   logic [2:0]           txc_reg;
   logic [2:0]           rsc_reg;
   logic [2:0]           lk_reg;
   logic [2:0]           sd_reg;
   logic [cpc_pkg::CW-1:0] txw1_reg;
   logic [cpc_pkg::CW-1:0] txw2_reg;
   logic [cpc_pkg::CW-1:0] txw3_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txc_reg  <= 3'h0;
         rsc_reg  <= 3'h0;
         lk_reg   <= 3'h0;
         sd_reg   <= 3'h0;
         txw1_reg <= 10'h000;
         txw2_reg <= 10'h000;
         txw3_reg <= 10'h000;
      end else if (ce_i) begin
         txc_reg  <= {txc_reg[1:0], tx_word_clock_i};
         rsc_reg  <= {rsc_reg[1:0], rx_word_clock_i};
         lk_reg   <= {lk_reg[1:0], rx_pll_locked_i};
         sd_reg   <= {sd_reg[1:0], rx_sig_detect_i};
         txw1_reg <= tx_word_i;
         txw2_reg <= txw1_reg;
         txw3_reg <= txw2_reg;
      end
   end

   logic tx_edge;
   logic rs_edge;
   logic locked;
   // Stage 3 holds the word sampled just before the edge was seen
   assign tx_edge = txc_reg[1] & ~txc_reg[2];
   assign rs_edge = rsc_reg[1] ^ rsc_reg[2];
   assign locked  = lk_reg[1];

   // ****************************************
   // Transmit path
   // ****************************************
   logic        tx_rd_reg;
   logic        tx_rd_used_reg;
   logic [10:0] tx_enc;
   logic [10:0] rt_dec;
   // Bit 9 is ignored in eight-bit mode; host keeps it low
   assign tx_enc = enc(txw3_reg[7:0], txw3_reg[8], tx_rd_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_code_o     <= 10'h000;
         tx_code_stb_o <= 1'b0;
         tx_rd_reg     <= 1'b0;
         tx_rd_used_reg <= 1'b0;
      end else if (ce_i) begin
         tx_code_stb_o <= tx_edge;
         if (tx_edge) begin
            if (ctrl_reg.mode8) begin
               tx_code_o <= tx_enc[9:0];
               tx_rd_reg <= tx_enc[10];
               tx_rd_used_reg <= tx_rd_reg;
            end else begin
               tx_code_o <= txw3_reg;
            end
         end
      end
   end

   // ****************************************
   // Receive alignment and decoding
   // ****************************************
   logic [cpc_pkg::CW-1:0] sh_reg;
   logic [3:0]             cnt_reg;
   logic                   rx_rd_reg;
   logic [cpc_pkg::CW-1:0] sh_next;
   logic                   comma_hit;
   logic                   emit;
   logic [10:0]            rx_dec;
   logic                   bit_take;

   // Bits are dropped while the PLL is unlocked
   assign bit_take  = rx_bit_stb_i & locked;
   assign sh_next   = {sh_reg[8:0], rx_bit_i};
   assign comma_hit = bit_take & (sh_next[9:3] == cpc_pkg::COMMA_POS ||
                                  sh_next[9:3] == cpc_pkg::COMMA_NEG);
   assign emit      = bit_take & ((comma_hit & ctrl_reg.align_en) ||
                                  cnt_reg == 4'(cpc_pkg::CW - 1));
   assign rx_dec    = dec(sh_next, rx_rd_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_reg    <= 10'h000;
         cnt_reg   <= 4'h0;
         rx_rd_reg <= 1'b0;
      end else if (ce_i) begin
         if (bit_take) begin
            sh_reg  <= sh_next;
            cnt_reg <= emit ? 4'h0 : cnt_reg + 4'h1;
         end
         if (emit && ctrl_reg.mode8)
            rx_rd_reg <= rx_dec[10];
      end
   end

   // ****************************************
   // Receive word launch
   // ****************************************
   logic [cpc_pkg::CW-1:0] pend_reg;
   logic                   pend_v_reg;
   logic [1:0]             rc_reg;
   logic                   launch;

   // Write mode launches at once, read mode on either strobe edge
   assign launch = ctrl_reg.read_mode ? rs_edge : pend_v_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg   <= 10'h000;
         pend_v_reg <= 1'b0;
      end else if (ce_i) begin
         if (emit) begin
            // Decoded word already has the flag layout of the output
            pend_reg   <= ctrl_reg.mode8 ? rx_dec[9:0] : sh_next;
            pend_v_reg <= 1'b1;
         end else if (launch) begin
            pend_v_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_parallel_word_o <= 10'h000;
      end else if (ce_i && launch) begin
         if (pend_v_reg)
            rx_parallel_word_o <= pend_reg;
         else if (ctrl_reg.mode8)
            // Underrun repeats the word but never the violation flag
            rx_parallel_word_o[9] <= 1'b0;
      end
   end

   // Falling edge moves the word, rising edge marks it stable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_word_clock_o    <= 1'b1;
         rx_word_clock_oe_o <= 1'b0;
         rc_reg             <= 2'h0;
      end else if (ce_i) begin
         rx_word_clock_oe_o <= ~ctrl_reg.read_mode;
         if (launch && !ctrl_reg.read_mode) begin
            rx_word_clock_o <= 1'b0;
            rc_reg          <= cpc_pkg::REC_LOW_CYC;
         end else if (rc_reg != 2'h0) begin
            rc_reg <= rc_reg - 2'h1;
            if (rc_reg == 2'h1)
               rx_word_clock_o <= 1'b1;
         end
      end
   end

   // ****************************************
   // Status pins
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_pll_lock_n_o     <= 1'b1;
         signal_loss_flag_o  <= 1'b0;
         comma_detect_flag_o <= 1'b0;
         rate_sel_o          <= 1'b0;
      end else if (ce_i) begin
         rx_pll_lock_n_o    <= ~locked;
         signal_loss_flag_o <= ctrl_reg.mode8 & ~sd_reg[1];
         rate_sel_o         <= ctrl_reg.rate_low;
         if (!locked)
            comma_detect_flag_o <= 1'b0;
         else if (comma_hit)
            comma_detect_flag_o <= 1'b1;
      end
   end

   // ****************************************
   // Register bus and interrupts
   // ****************************************
   cpc_pkg::cpc_evt_t irq_reg;
   cpc_pkg::cpc_evt_t mask_reg;
   cpc_pkg::cpc_evt_t evt;
   cpc_pkg::cpc_evt_t irq_next;
   logic              wr_lo;
   logic              rd_irq;

   assign evt.viol      = emit & ctrl_reg.mode8 & rx_dec[9];
   assign evt.comma     = comma_hit;
   assign evt.sig_lost  = ctrl_reg.mode8 & sd_reg[2] & ~sd_reg[1];
   assign evt.lock_lost = lk_reg[2] & ~lk_reg[1];
   assign wr_lo  = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
   assign rd_irq = wb_ack_o & wb_cyc_i & wb_stb_i & ~wb_we_i &
                   (wb_adr_i == cpc_pkg::ADR_IRQ);
   // Clear only bits that were read out; a new event outranks the clear
   assign irq_next = (irq_reg & ~(wb_dat_o[3:0] & {4{rd_irq}})) | evt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         case (wb_adr_i)
            cpc_pkg::ADR_CTRL:   wb_dat_o <= {28'h0000000, ctrl_reg};
            cpc_pkg::ADR_STATUS: wb_dat_o <= {28'h0000000, comma_detect_flag_o,
                                              ~sd_reg[1], locked, pend_v_reg};
            cpc_pkg::ADR_IRQ:    wb_dat_o <= {28'h0000000, irq_reg};
            cpc_pkg::ADR_MASK:   wb_dat_o <= {28'h0000000, mask_reg};
            default:             wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= cpc_pkg::CTRL_RST;
         mask_reg <= cpc_pkg::MASK_RST;
      end else if (ce_i && wr_lo) begin
         // Mode is sampled live; change it only with the link idle
         if (wb_adr_i == cpc_pkg::ADR_CTRL)
            ctrl_reg <= wb_dat_i[3:0];
         if (wb_adr_i == cpc_pkg::ADR_MASK)
            mask_reg <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 4'h0;
         irq_o   <= 1'b0;
      end else if (ce_i) begin
         irq_reg <= irq_next;
         irq_o   <= |(irq_next & mask_reg);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   // Decodes the last sent group with the disparity it was built from
   assign rt_dec = dec(tx_code_o, tx_rd_used_reg);

   a_tx_raw_word: assert property (
      !ctrl_reg.mode8 && tx_edge |=> tx_code_o == $past(txw3_reg) && tx_code_stb_o)
      else $error("raw transmit word not passed through");
   a_tx_round_trip: assert property (
      ctrl_reg.mode8 && tx_edge |=>
         rt_dec[9:0] == {1'b0, $past(txw3_reg[8:0])})
      else $error("encoded word does not decode back");
   a_rate_follows: assert property (
      wr_lo && wb_adr_i == cpc_pkg::ADR_CTRL |=> ##1 rate_sel_o == $past(wb_dat_i[3], 2))
      else $error("rate select did not follow control write");
   a_rx_raw_word: assert property (
      emit && !ctrl_reg.mode8 |=> pend_reg == $past(sh_next))
      else $error("raw receive word altered");
   a_rx_k_flag: assert property (
      emit && ctrl_reg.mode8 && (sh_next[9:4] == cpc_pkg::K28_SIX ||
      sh_next[9:4] == ~cpc_pkg::K28_SIX) |=> pend_reg[8])
      else $error("control group not flagged");
   a_viol_single: assert property (
      launch && !pend_v_reg && ctrl_reg.mode8 |=> !rx_parallel_word_o[9])
      else $error("violation flag held over two words");
   a_rec_clock: assert property (
      launch && !ctrl_reg.read_mode |=> !rx_word_clock_o [*2] ##1 rx_word_clock_o)
      else $error("recovered clock shape wrong");
   a_read_launch: assert property (
      ctrl_reg.read_mode && rs_edge && pend_v_reg |=>
         rx_parallel_word_o == $past(pend_reg))
      else $error("word not launched on strobe edge");
   a_los_mode: assert property (
      !ctrl_reg.mode8 |=> !signal_loss_flag_o)
      else $error("signal loss shown outside eight-bit mode");
   a_lock_out: assert property (
      locked ##1 locked |-> !rx_pll_lock_n_o)
      else $error("lock output high while locked");
   a_comma_align: assert property (
      comma_hit && ctrl_reg.align_en |=> cnt_reg == 4'h0 && comma_detect_flag_o)
      else $error("comma did not realign the boundary");

   c_viol_seen:  cover property (evt.viol);
   c_read_mode:  cover property (ctrl_reg.read_mode && launch && pend_v_reg);
   c_comma_algn: cover property (comma_hit && ctrl_reg.align_en);
   c_irq_raised: cover property ($rose(irq_o));

endmodule : cpc_codec_path

// File: verification/cpc_far_end.sv
// Purpose: Far-end model: host framer and deserializer front end
// Assumes: Shares clk_i with the codec path; drives just after edges
// Notes:   Transmit word clock toggles only while a word is sent
`timescale 1ns/1ps
module cpc_far_end (
   input  wire logic       clk_i,
   output logic            tx_clk_o,
   output logic [9:0]      tx_word_o,
   output logic            bit_o,
   output logic            bit_stb_o
);
   initial begin
      tx_clk_o  = 1'h0;
      tx_word_o = 10'h000;
      bit_o     = 1'h0;
      bit_stb_o = 1'h0;
   end

   // One 325 ns word period; word held well around the rising edge
   task automatic send_word(input logic [9:0] w);
      tx_word_o <= w;
      repeat (4) @(posedge clk_i);
      tx_clk_o <= 1'h1;
      repeat (4) @(posedge clk_i);
      tx_clk_o <= 1'h0;
      repeat (4) @(posedge clk_i);
      tx_word_o <= ~w;
      @(posedge clk_i);
   endtask : send_word

   // First bit sent is bit 9; gap stretches the word for a slow link
   task automatic send_bits(input logic [9:0] w, input int gap);
      for (int i = 9; i >= 0; i--) begin
         bit_o     <= w[i];
         bit_stb_o <= 1'h1;
         @(posedge clk_i);
         if (gap > 0) begin
            bit_o     <= ~w[i];
            bit_stb_o <= 1'h0;
            repeat (gap) @(posedge clk_i);
         end
      end
      bit_o     <= ~w[0];
      bit_stb_o <= 1'h0;
   endtask : send_bits
endmodule : cpc_far_end

// File: verification/cpc_codec_path_bench.sv
// Purpose: Self-checking bench for the CPRI parallel codec path
// Assumes: Far end shares clk_i; registers over classic Wishbone
// Notes:   Expected code-groups worked out by hand from the 8b/10b code
`timescale 1ns/1ps
module cpc_codec_path_bench;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq, stb_pin, lockd, sigd, pin;
   logic        tx_word_clock, bit_v, bit_s, tx_stb, rate, rxck_o, rxck_oe, signal_loss_flag, lock_n, comma;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [9:0]  txw, tx_code, rx_word;
   int          fails, tests_run;

   // Shared receive clock pin: strobe from the bench only in read mode
   assign pin = rxck_oe ? rxck_o : stb_pin;

   cpc_codec_path DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_o(irq), .tx_word_clock_i(tx_word_clock), .tx_word_i(txw),
      .tx_code_o(tx_code), .tx_code_stb_o(tx_stb), .rate_sel_o(rate), .rx_bit_i(bit_v),
      .rx_bit_stb_i(bit_s), .rx_pll_locked_i(lockd), .rx_sig_detect_i(sigd),
      .rx_parallel_word_o(rx_word), .rx_word_clock_i(pin), .rx_word_clock_o(rxck_o),
      .rx_word_clock_oe_o(rxck_oe), .signal_loss_flag_o(signal_loss_flag), .rx_pll_lock_n_o(lock_n),
      .comma_detect_flag_o(comma)
   );

   cpc_far_end pm (
      .clk_i(clk_i), .tx_clk_o(tx_word_clock), .tx_word_o(txw), .bit_o(bit_v), .bit_stb_o(bit_s)
   );

   initial begin
      clk_i = 1'h0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ****************
   // Helpers
   // ****************
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_lvl(ref logic s, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (s !== v && n < 200);
      if (n >= 200) begin
         fails++;
         print_verdict();
      end
   endtask : wait_lvl

   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      adr  <= a;
      we   <= w;
      wdat <= d;
      cyc  <= 1'h1;
      stb  <= 1'h1;
      wait_lvl(ack, 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk_i);
   endtask : wb

   task automatic tx(input logic [9:0] w, input logic [9:0] exp);
      fork
         pm.send_word(w);
         wait_lvl(tx_stb, 1'h1);
      join
      check("tx code", tx_code, exp);
   endtask : tx

   task automatic rx(input logic [9:0] w, input logic [9:0] exp);
      fork
         pm.send_bits(w, 0);
         wait_lvl(rxck_o, 1'h0);
      join
      check("rx word", rx_word, exp);
      repeat (3) @(posedge clk_i);
   endtask : rx

   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      print_verdict();
   end

   // ****************
   // Main sequence
   // ****************
   initial begin
      rst_i = 1'h1;
      {cyc, stb, we, stb_pin, lockd} = 5'h00;
      sigd = 1'h1;
      adr = 4'h0;
      wdat = 32'h0;
      fails = 0;
      tests_run = 0;
      repeat (4) @(posedge clk_i);
      check("lock_n in reset", lock_n, 32'h1);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      check("rx clock drive", rxck_oe, 32'h1);
      wb(cpc_pkg::ADR_CTRL, 1'h0, 32'h0);
      check("ctrl reset", q, 32'h0);
      wb(cpc_pkg::ADR_MASK, 1'h0, 32'h0);
      check("mask reset", q, 32'h0);
      wb(4'h2, 1'h0, 32'h0);
      check("unmapped read", q, 32'h0);
      wb(cpc_pkg::ADR_CTRL, 1'h1, 32'h1);
      tx(10'h000, 10'h274);
      tx(10'h1bc, 10'h0fa);
      wb(cpc_pkg::ADR_CTRL, 1'h1, 32'h8);
      repeat (2) @(posedge clk_i);
      check("rate select", rate, 32'h1);
      tx(10'h2a5, 10'h2a5);
      lockd <= 1'h1;
      repeat (6) @(posedge clk_i);
      check("lock_n locked", lock_n, 32'h0);
      wb(cpc_pkg::ADR_CTRL, 1'h1, 32'h0);
      rx(10'h274, 10'h274);
      wb(cpc_pkg::ADR_MASK, 1'h1, 32'h1);
      wb(cpc_pkg::ADR_CTRL, 1'h1, 32'h3);
      rx(10'h0fa, 10'h1bc);
      check("comma flag", comma, 32'h1);
      check("irq masked", irq, 32'h0);
      // Negative-disparity D0.0 after K28.5 is a disparity violation
      rx(10'h274, 10'h200);
      check("irq raised", irq, 32'h1);
      wb(cpc_pkg::ADR_IRQ, 1'h0, 32'h0);
      check("irq status", q, 32'h3);
      repeat (3) @(posedge clk_i);
      check("irq cleared", irq, 32'h0);
      sigd <= 1'h0;
      repeat (6) @(posedge clk_i);
      check("loss flag", signal_loss_flag, 32'h1);
      wb(cpc_pkg::ADR_CTRL, 1'h1, 32'h4);
      repeat (6) @(posedge clk_i);
      check("loss in 10-bit", signal_loss_flag, 32'h0);
      check("rx clock input", rxck_oe, 32'h0);
      pm.send_bits(10'h18b, 1);
      stb_pin <= 1'h1;
      repeat (8) @(posedge clk_i);
      check("read rising", rx_word, 32'h18b);
      pm.send_bits(10'h274, 1);
      stb_pin <= 1'h0;
      repeat (8) @(posedge clk_i);
      check("read falling", rx_word, 32'h274);
      lockd <= 1'h0;
      repeat (6) @(posedge clk_i);
      check("lock_n lost", lock_n, 32'h1);
      check("comma unlocked", comma, 32'h0);
      wb(cpc_pkg::ADR_IRQ, 1'h0, 32'h0);
      check("lock and loss events", q & 32'hc, 32'hc);
      print_verdict();
   end
endmodule : cpc_codec_path_bench
